// ### pkg/tsf_regs.svh
// register offsets, field positions and codes of the sample buffer
`ifndef TSF_REGS_SVH
`define TSF_REGS_SVH
`define TSF_A_CTRL_ONE 8'h07
`define TSF_A_CTRL_TWO 8'h08
`define TSF_A_CTRL_FOUR 8'h0A
`define TSF_A_STAT_LOW 8'h3A
`define TSF_A_STAT_HIGH 8'h3B
`define TSF_A_OUT_TAG 8'h78
`define TSF_A_OUT_LAST 8'h7E
`define TSF_B_THR_MSB 0
`define TSF_B_THR_STOP 7
`define TSF_B_THR_FLAG 7
`define TSF_B_FULL_FLAG 6
`define TSF_B_OVR_FLAG 5
`define TSF_B_OVR_STICKY 3
`define TSF_M_BYPASS 3'b000
`define TSF_M_STOP 3'b001
`define TSF_M_CONT 3'b110
`define TSF_M_BYP_CONT 3'b100
`define TSF_M_BYP_STOP 3'b111
`define TSF_WORD_BYTES 7
`endif

// ### pkg/tsf_pkg.sv
// types of the triggered sample buffer
package tsf_pkg;
    typedef enum logic [2:0] {
        S_BYPASS,
        S_STOP,
        S_CONT,
        S_WAIT_CONT,
        S_WAIT_STOP
    } tsf_state_t;
endpackage

// ### hw/tsf_triggered_sample_fifo_ctrl.sv
// triggered sample buffer controller with register port
//
// Overview of operation
// - bypass-then-continuous: empty until wake-up, then overwrite
// - first wake-up edge switches; holds until next mode write
// - mode code 100b selects bypass-then-continuous
// - full flag when next sample fills or overruns
// - bypass-then-stop: empty until wake-up, then stop-when-full
// - mode code 111b selects bypass-then-stop
// - triggered stop mode: full flag, then stop storing
// - output read returns oldest stored word
// - after word read, free slot, load next oldest
// - ten-bit stored word count, zero when empty
// - burst address wraps last data byte to tag
// - nine-bit watermark threshold over two registers
// - watermark flag when count at least threshold
// - stop-at-threshold limits capacity to threshold
// - without limit, threshold only raises watermark flag
// - limited buffer: full and watermark flags track limit
// - code 000b bypass clears buffer, keeps it empty
// - code 001b fills until full, then holds contents
// - continuous full buffer overwrites oldest word
// - overrun flag, immediate and sticky, on overwrite
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "tsf_regs.svh"

module tsf_triggered_sample_fifo_ctrl
    import tsf_pkg::*;
#(
    parameter int DEPTH = 512,
    parameter int PTR_W = 9
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_burst_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sample_valid_i,
    input wire logic [55:0] sample_word_i,
    input wire logic second_irq_line_i,
    output logic buffer_full_flag_o,
    output logic watermark_reached_flag_o,
    output logic overrun_flag_o,
    output logic overrun_sticky_flag_o,
    output logic [9:0] stored_word_count_o,
    output logic triggered_o
);

    if (DEPTH != (1 << PTR_W) || DEPTH > 512 || DEPTH < 2) begin : g_depth_chk
        $error("depth must be a power of two up to 512");
    end

    logic [55:0] mem [DEPTH];
    tsf_state_t state_r;
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [9:0] count_r;
    logic [9:0] count_nxt;
    logic [8:0] thr_r;
    logic thr_stop_r;
    logic [2:0] mode_r;
    logic stopped_r;
    logic wk_s1_r;
    logic wk_s2_r;
    logic wk_s3_r;
    logic trig;
    logic [7:0] burst_addr_r;
    logic [7:0] eff_addr;
    logic [9:0] cap;
    logic ctrl4_wr;
    logic pop;
    logic push;
    logic overwrite;
    logic room;
    logic [55:0] head;
    logic [7:0] rdata_r;
    logic full_r;
    logic thr_flag_r;
    logic ovr_r;
    logic ovr_sticky_r;

    function automatic logic is_out(input logic [7:0] a);
        is_out = (a >= `TSF_A_OUT_TAG) && (a <= `TSF_A_OUT_LAST);
    endfunction

    function automatic logic [7:0] next_addr(input logic [7:0] a);
        if (a == `TSF_A_OUT_LAST) begin
            next_addr = `TSF_A_OUT_TAG;
        end else begin
            next_addr = a + 8'h01;
        end
    endfunction

    function automatic tsf_state_t mode_state(input logic [2:0] m);
        case (m)
            `TSF_M_STOP: mode_state = S_STOP;
            `TSF_M_CONT: mode_state = S_CONT;
            `TSF_M_BYP_CONT: mode_state = S_WAIT_CONT;
            `TSF_M_BYP_STOP: mode_state = S_WAIT_STOP;
            default: mode_state = S_BYPASS;
        endcase
    endfunction

    // burst reads follow the internal cursor
    assign eff_addr = reg_burst_i ? burst_addr_r : reg_addr_i;
    assign ctrl4_wr = reg_wr_i && (reg_addr_i == `TSF_A_CTRL_FOUR);
    assign trig = wk_s2_r && !wk_s3_r;
    assign cap = thr_stop_r ? {1'b0, thr_r} : DEPTH[9:0];
    assign head = mem[rd_ptr_r];
    assign room = count_r < cap;

    // word freed once its last byte leaves
    assign pop = reg_rd_i && (eff_addr == `TSF_A_OUT_LAST)
        && (count_r != 10'h000) && (state_r != S_BYPASS);

    always_comb begin
        push = 1'b0;
        overwrite = 1'b0;
        if (sample_valid_i && !ctrl4_wr) begin
            case (state_r)
                S_STOP: push = !stopped_r && room;
                S_CONT: begin
                    push = cap != 10'h000;
                    overwrite = push && !room && !pop;
                end
                default: push = 1'b0;
            endcase
        end
    end

    always_comb begin
        count_nxt = count_r;
        if (push && !overwrite && !pop) begin
            count_nxt = count_r + 10'h001;
        end else if (pop && !push) begin
            count_nxt = count_r - 10'h001;
        end
    end

    // wake-up synchroniser and edge detect
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wk_s1_r <= 1'b0;
            wk_s2_r <= 1'b0;
            wk_s3_r <= 1'b0;
        end else if (ce_i) begin
            wk_s1_r <= second_irq_line_i;
            wk_s2_r <= wk_s1_r;
            wk_s3_r <= wk_s2_r;
        end
    end

    // control registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            thr_r <= 9'h000;
            thr_stop_r <= 1'b0;
            mode_r <= `TSF_M_BYPASS;
        end else if (ce_i && reg_wr_i) begin
            case (reg_addr_i)
                `TSF_A_CTRL_ONE: thr_r[7:0] <= reg_wdata_i;
                `TSF_A_CTRL_TWO: begin
                    thr_r[8] <= reg_wdata_i[`TSF_B_THR_MSB];
                    thr_stop_r <= reg_wdata_i[`TSF_B_THR_STOP];
                end
                `TSF_A_CTRL_FOUR: mode_r <= reg_wdata_i[2:0];
                default: mode_r <= mode_r;
            endcase
        end
    end

    // mode state: wait states arm on the first edge
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= S_BYPASS;
        end else if (ce_i) begin
            if (ctrl4_wr) begin
                state_r <= mode_state(reg_wdata_i[2:0]);
            end else if (trig && state_r == S_WAIT_CONT) begin
                state_r <= S_CONT;
            end else if (trig && state_r == S_WAIT_STOP) begin
                state_r <= S_STOP;
            end
        end
    end

    // storage and pointers
    always_ff @(posedge clock_i) begin
        if (ce_i && push) begin
            mem[wr_ptr_r] <= sample_word_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= 10'h000;
            stopped_r <= 1'b0;
        end else if (ce_i) begin
            if (ctrl4_wr || state_r == S_BYPASS
                || state_r == S_WAIT_CONT || state_r == S_WAIT_STOP) begin
                wr_ptr_r <= '0;
                rd_ptr_r <= '0;
                count_r <= 10'h000;
                stopped_r <= 1'b0;
            end else begin
                if (push) begin
                    wr_ptr_r <= wr_ptr_r + 1'b1;
                end
                if (pop || overwrite) begin
                    rd_ptr_r <= rd_ptr_r + 1'b1;
                end
                count_r <= count_nxt;
                if (state_r == S_STOP && count_nxt >= cap) begin
                    stopped_r <= 1'b1;
                end
            end
        end
    end

    // status flags
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            full_r <= 1'b0;
            thr_flag_r <= 1'b0;
            ovr_r <= 1'b0;
        end else if (ce_i) begin
            // next write fills or overruns the current capacity
            full_r <= (state_r == S_STOP || state_r == S_CONT)
                && (count_r + 10'h001 >= cap);
            thr_flag_r <= count_r >= {1'b0, thr_r};
            if (overwrite) begin
                ovr_r <= 1'b1;
            end else if (pop || state_r != S_CONT) begin
                ovr_r <= 1'b0;
            end
        end
    end

    // sticky overrun, cleared by reading status high; set wins
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ovr_sticky_r <= 1'b0;
        end else if (ce_i) begin
            if (overwrite) begin
                ovr_sticky_r <= 1'b1;
            end else if (reg_rd_i && eff_addr == `TSF_A_STAT_HIGH) begin
                ovr_sticky_r <= 1'b0;
            end
        end
    end

    // read path and burst cursor
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
            burst_addr_r <= `TSF_A_OUT_TAG;
        end else if (ce_i) begin
            if (reg_rd_i) begin
                burst_addr_r <= next_addr(eff_addr);
                rdata_r <= 8'h00;
                if (is_out(eff_addr)) begin
                    if (count_r != 10'h000 && state_r != S_BYPASS) begin
                        rdata_r <= head[(eff_addr - `TSF_A_OUT_TAG) * 8 +: 8];
                    end
                end else begin
                    case (eff_addr)
                        `TSF_A_CTRL_ONE: rdata_r <= thr_r[7:0];
                        `TSF_A_CTRL_TWO: begin
                            rdata_r[`TSF_B_THR_MSB] <= thr_r[8];
                            rdata_r[`TSF_B_THR_STOP] <= thr_stop_r;
                        end
                        `TSF_A_CTRL_FOUR: rdata_r <= {5'h00, mode_r};
                        `TSF_A_STAT_LOW: rdata_r <= count_r[7:0];
                        `TSF_A_STAT_HIGH: begin
                            rdata_r[`TSF_B_THR_FLAG] <= thr_flag_r;
                            rdata_r[`TSF_B_FULL_FLAG] <= full_r;
                            rdata_r[`TSF_B_OVR_FLAG] <= ovr_r;
                            rdata_r[`TSF_B_OVR_STICKY] <= ovr_sticky_r;
                            rdata_r[1:0] <= count_r[9:8];
                        end
                        default: rdata_r <= 8'h00;
                    endcase
                end
            end
        end
    end

    assign reg_rdata_o = rdata_r;
    assign buffer_full_flag_o = full_r;
    assign watermark_reached_flag_o = thr_flag_r;
    assign overrun_flag_o = ovr_r;
    assign overrun_sticky_flag_o = ovr_sticky_r;
    assign stored_word_count_o = count_r;
    assign triggered_o = (state_r == S_CONT || state_r == S_STOP)
        && (mode_r == `TSF_M_BYP_CONT || mode_r == `TSF_M_BYP_STOP);

    a_bypass_empty: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == S_BYPASS |=> count_r == 10'h000)
        else $error("bypass left words stored");
    a_wait_empty: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == S_WAIT_CONT || state_r == S_WAIT_STOP) && ce_i
        |=> count_r == 10'h000 && !full_r)
        else $error("waiting buffer not empty");
    a_trigger_cont: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !ctrl4_wr && state_r == S_WAIT_CONT && trig
        |=> state_r == S_CONT)
        else $error("edge did not start continuous storage");
    a_trigger_stop: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && !ctrl4_wr && state_r == S_WAIT_STOP && trig
        |=> state_r == S_STOP)
        else $error("edge did not start stop storage");
    a_edge_single: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && trig |=> !trig)
        else $error("trigger pulse longer than one cycle");
    a_stop_holds: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == S_STOP && stopped_r && !pop && !ctrl4_wr
        |=> $stable(count_r) && $stable(wr_ptr_r))
        else $error("stopped buffer kept storing");
    a_pop_count: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && pop && !push && !ctrl4_wr
        |=> count_r == $past(count_r) - 10'h001 && rd_ptr_r != $past(rd_ptr_r))
        else $error("read word not freed");
    a_watermark_flag: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && count_r >= {1'b0, thr_r} |=> thr_flag_r)
        else $error("watermark flag missing");
    a_full_flag: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && state_r == S_CONT && count_r + 10'h001 >= cap |=> full_r)
        else $error("full flag missing");
    a_overrun_sticky: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && overwrite |=> ovr_r && ovr_sticky_r && count_r == $past(count_r))
        else $error("overwrite not flagged");
    a_count_limit: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && thr_stop_r && $stable(thr_r) && count_r <= cap
        |=> count_r <= {1'b0, thr_r})
        else $error("limited buffer exceeded threshold");
    a_burst_wrap: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && reg_rd_i && eff_addr == `TSF_A_OUT_LAST
        |=> burst_addr_r == `TSF_A_OUT_TAG)
        else $error("burst cursor did not wrap");

endmodule

// ### verif/tsf_sample_source.sv
// sensor side model: sample pulses and wake-up line
`timescale 1ns/10ps
module tsf_sample_source (
    input wire logic clock_i,
    output logic sample_valid_o,
    output logic [55:0] sample_word_o,
    output logic wake_o
);
    initial begin
        sample_valid_o = 1'b0;
        sample_word_o = '0;
        wake_o = 1'b0;
    end
    // one pulse per word, data scrambled outside the pulse
    task automatic send(input logic [55:0] w);
        @(posedge clock_i);
        sample_valid_o <= 1'b1;
        sample_word_o <= w;
        @(posedge clock_i);
        sample_valid_o <= 1'b0;
        sample_word_o <= ~w;
    endtask
    // wake-up routed to the second line, held a few cycles
    task automatic wake();
        @(posedge clock_i);
        wake_o <= 1'b1;
        repeat (6) @(posedge clock_i);
        wake_o <= 1'b0;
    endtask
endmodule

// ### verif/tb_tsf_triggered_sample_fifo_ctrl.sv
// self-checking bench of the triggered sample buffer
`timescale 1ns/10ps
`include "tsf_regs.svh"
`define TSF_CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_tsf_triggered_sample_fifo_ctrl;
    logic clock_i, rst_i, ce_i, reg_wr_i, reg_rd_i, reg_burst_i, rd_pend;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, e8;
    logic sample_valid_i, second_irq_line_i, triggered_o;
    logic [55:0] sample_word_i;
    logic buffer_full_flag_o, watermark_reached_flag_o, overrun_flag_o, overrun_sticky_flag_o;
    logic [9:0] stored_word_count_o;
    logic [7:0] exp_q[$];
    logic [55:0] mq[$];
    int num_errors, checked, cap;
    bit cont, run, stopped, ovr;
    localparam logic [7:0] hi_all = 8'((1 << `TSF_B_THR_FLAG) | (1 << `TSF_B_FULL_FLAG)
        | (1 << `TSF_B_OVR_FLAG) | (1 << `TSF_B_OVR_STICKY));

    tsf_triggered_sample_fifo_ctrl #(.DEPTH(8), .PTR_W(3)) i_tsf_triggered_sample_fifo_ctrl (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_burst_i(reg_burst_i), .reg_rdata_o(reg_rdata_o),
        .sample_valid_i(sample_valid_i), .sample_word_i(sample_word_i),
        .second_irq_line_i(second_irq_line_i), .buffer_full_flag_o(buffer_full_flag_o),
        .watermark_reached_flag_o(watermark_reached_flag_o), .overrun_flag_o(overrun_flag_o),
        .overrun_sticky_flag_o(overrun_sticky_flag_o),
        .stored_word_count_o(stored_word_count_o), .triggered_o(triggered_o));
    tsf_sample_source i_src (.clock_i(clock_i), .sample_valid_o(sample_valid_i),
        .sample_word_o(sample_word_i), .wake_o(second_irq_line_i));

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // read data stands from the cycle after the strobe until the next read strobe
    always @(posedge clock_i) rd_pend <= reg_rd_i;
    always @(negedge clock_i) if (rd_pend === 1'b1) begin
        e8 = exp_q.pop_front();
        `TSF_CHK("read data", e8, reg_rdata_o)
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        end_of_test();
    end
    task automatic acc(input logic [7:0] a, input logic b, input logic [7:0] e);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_wr_i <= 1'b0;
        reg_addr_i <= a;
        reg_burst_i <= b;
        exp_q.push_back(e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        reg_addr_i <= a;
        reg_wdata_i <= d;
    endtask
    task automatic idle();
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        reg_burst_i <= 1'b0;
        reg_wdata_i <= 8'($urandom);
    endtask
    // mode write clears the buffer and the model
    task automatic setmode(input logic [2:0] m);
        wr(`TSF_A_CTRL_FOUR, {5'h00, m});
        idle();
        @(negedge clock_i);
        mq.delete();
        ovr = 0;
        stopped = 0;
        run = (m == `TSF_M_STOP || m == `TSF_M_CONT);
        cont = (m == `TSF_M_CONT || m == `TSF_M_BYP_CONT);
    endtask
    task automatic smp(input int n);
        logic [55:0] w;
        repeat (n) begin
            w[55:24] = $urandom;
            w[23:0] = 24'($urandom);
            i_src.send(w);
            if (run && !stopped) begin
                if (mq.size() < cap) begin
                    mq.push_back(w);
                end else if (cont) begin
                    mq.delete(0);
                    mq.push_back(w);
                    ovr = 1;
                end
                if (!cont && mq.size() == cap) stopped = 1;
            end
        end
    endtask
    task automatic chk(input logic fl);
        logic [9:0] c;
        c = 10'(mq.size());
        idle();
        repeat (3) @(posedge clock_i);
        `TSF_CHK("count", c, stored_word_count_o)
        `TSF_CHK("full", fl, buffer_full_flag_o)
        `TSF_CHK("overrun", ovr, overrun_flag_o)
        acc(`TSF_A_STAT_LOW, 1'b0, c[7:0]);
        idle();
    endtask
    // one word as a seven byte burst from the tag
    task automatic rdword();
        logic [55:0] w;
        w = mq.pop_front();
        ovr = 0;
        for (int k = 0; k < 7; k++) acc(8'h78 + 8'(k), k != 0, w[8*k +: 8]);
    endtask
    task automatic trig();
        i_src.wake();
        run = 1;
        @(negedge clock_i);
        `TSF_CHK("trigger", 1'b1, triggered_o)
    endtask

    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        {reg_wr_i, reg_rd_i, reg_burst_i, reg_addr_i, reg_wdata_i} = '0;
        num_errors = 0;
        checked = 0;
        {cont, run, stopped, ovr} = '0;
        cap = 8;
        void'($urandom(32'h9a2f));
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        chk(1'b0);
        smp(3);
        chk(1'b0);
        setmode(`TSF_M_BYP_CONT);
        smp(4);
        chk(1'b0);
        trig();
        smp(9);
        chk(1'b1);
        `TSF_CHK("sticky", 1'b1, overrun_sticky_flag_o)
        acc(`TSF_A_STAT_HIGH, 1'b0, hi_all);
        idle();
        @(negedge clock_i);
        `TSF_CHK("sticky clear", 1'b0, overrun_sticky_flag_o)
        i_src.wake();
        smp(1);
        chk(1'b1);
        rdword();
        rdword();
        chk(1'b0);
        setmode(`TSF_M_BYPASS);
        `TSF_CHK("trigger", 1'b0, triggered_o)
        setmode(`TSF_M_BYP_STOP);
        smp(2);
        chk(1'b0);
        trig();
        smp(10);
        chk(1'b1);
        repeat (8) rdword();
        acc(8'h78, 1'b0, 8'h00);
        chk(1'b0);
        setmode(`TSF_M_BYPASS);
        wr(`TSF_A_CTRL_ONE, 8'h03);
        wr(`TSF_A_CTRL_TWO, 8'h80);
        cap = 3;
        setmode(`TSF_M_STOP);
        smp(5);
        chk(1'b1);
        `TSF_CHK("watermark", 1'b1, watermark_reached_flag_o)
        wr(`TSF_A_CTRL_TWO, 8'h00);
        cap = 8;
        setmode(`TSF_M_CONT);
        smp(5);
        chk(1'b0);
        `TSF_CHK("watermark", 1'b1, watermark_reached_flag_o)
        @(posedge clock_i) ce_i <= 1'b0;
        i_src.send(56'h0);
        @(posedge clock_i) ce_i <= 1'b1;
        chk(1'b0);
        wr(`TSF_A_CTRL_TWO, 8'h01);
        chk(1'b0);
        `TSF_CHK("watermark", 1'b0, watermark_reached_flag_o)
        end_of_test();
    end
endmodule
